// *** rtl/jlle_pkg.sv ***
// jlle_pkg: constants for the jump-link and load execution block
// assumes a 64-bit core datapath; 32-bit operation is selected by a strap input
package jlle_pkg;
	// ************************************************************
	// widths and instruction fields
	// ************************************************************
	localparam int XLEN        = 64;
	localparam int OPC_HI      = 31;
	localparam int OPC_LO      = 26;
	localparam int FD_HI       = 25;
	localparam int FD_LO       = 21;
	localparam int FA_HI       = 20;
	localparam int FA_LO       = 16;
	localparam int FB_HI       = 15;
	localparam int FB_LO       = 11;
	localparam int IMM_HI      = 15;
	localparam int IMM_LO      = 0;
	localparam logic [4:0] LINK_REG_IDX = 5'h09;
	localparam logic [63:0] INSN_STEP   = 64'h0000000000000004;
	// ************************************************************
	// major opcodes
	// ************************************************************
	localparam logic [5:0] OP_JAL   = 6'h01;
	localparam logic [5:0] OP_JR    = 6'h11;
	localparam logic [5:0] OP_JALR  = 6'h12;
	localparam logic [5:0] OP_LBS   = 6'h24;
	localparam logic [5:0] OP_LBZ   = 6'h23;
	localparam logic [5:0] OP_LHS   = 6'h26;
	localparam logic [5:0] OP_LHZ   = 6'h25;
	localparam logic [5:0] OP_LD    = 6'h20;
	localparam logic [5:0] OP_LF    = 6'h1A;
	// ************************************************************
	// load size encoding and sequencer states
	// ************************************************************
	typedef enum logic [2:0] {JLLE_SZ_B, JLLE_SZ_H, JLLE_SZ_W, JLLE_SZ_D} jlle_size_t;
	typedef enum logic [1:0] {JLLE_IDLE, JLLE_SLOT, JLLE_LOAD} jlle_state_t;
endpackage

// *** rtl/jlle_load_ext.sv ***
// jlle_load_ext: shapes raw memory data into the destination value
// assumes memory data is already aligned to bit 0 by the memory system
`timescale 1ns/1ps
module jlle_load_ext (
	input  wire logic [jlle_pkg::XLEN-1:0] raw,
	input  wire logic [2:0]                size,
	input  wire logic                      sign_ext,
	input  wire logic                      nan_box,
	input  wire logic                      mode64,
	output logic      [jlle_pkg::XLEN-1:0] result
);
	import jlle_pkg::*;
	wire logic             b_fill = sign_ext & raw[7];
	wire logic             h_fill = sign_ext & raw[15];
	wire logic [XLEN-1:0]  ext_b  = {{(XLEN-8){b_fill}}, raw[7:0]};
	wire logic [XLEN-1:0]  ext_h  = {{(XLEN-16){h_fill}}, raw[15:0]};
	wire logic [31:0]      w_up   = (nan_box & mode64) ? 32'hFFFFFFFF : 32'h00000000;
	wire logic [XLEN-1:0]  ext_w  = {w_up, raw[31:0]};
	// pick by size; double word passes untouched
	assign result = (size == 3'(JLLE_SZ_B)) ? ext_b :
	                (size == 3'(JLLE_SZ_H)) ? ext_h :
	                (size == 3'(JLLE_SZ_W)) ? ext_w : raw;
endmodule

// *** rtl/jlle_exec.sv ***
// jlle_exec: executes jump-and-link, register jumps and sized loads
// assumes one instruction offered at a time with its operands already read
//
// Summary of operation
// - link gets jump or slot address plus four
// - register jumps take target register as pc
// - one delay slot unless no-slot config set
// - slot reads see the new link value
// - slot write to link overrides jump's link
// - register jumps check alignment; issued loads fault memory
// - address is base plus sign-extended immediate
// - signed byte fills upper bits with bit seven
// - unsigned byte clears upper bits
// - signed half copies bit fifteen, checks alignment
// - unsigned half clears upper bits, checks alignment
// - double load only in 64-bit mode
// - float load ones-fills upper half in 64-bit
// - byte loads never raise alignment faults
`timescale 1ns/1ps
module jlle_exec (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      insn_valid,
	input  wire logic [31:0]               insn,
	input  wire logic [jlle_pkg::XLEN-1:0] insn_addr,
	input  wire logic [jlle_pkg::XLEN-1:0] base_source_reg,
	input  wire logic [jlle_pkg::XLEN-1:0] target_source_reg,
	input  wire logic                      no_delay_slot_cfg,
	input  wire logic                      mode64,
	input  wire logic                      slot_wr_link,
	input  wire logic [jlle_pkg::XLEN-1:0] slot_wr_data,
	input  wire logic                      mem_ack,
	input  wire logic                      mem_err,
	input  wire logic                      mem_tlb_miss,
	input  wire logic                      mem_page_fault,
	input  wire logic [jlle_pkg::XLEN-1:0] mem_rdata,
	output logic                           insn_ready,
	output logic                           pc_load,
	output logic      [jlle_pkg::XLEN-1:0] pc_target,
	output logic      [jlle_pkg::XLEN-1:0] link_reg,
	output logic                           wb_valid,
	output logic      [4:0]                wb_dest,
	output logic      [jlle_pkg::XLEN-1:0] wb_data,
	output logic                           mem_req,
	output logic      [jlle_pkg::XLEN-1:0] effective_address,
	output logic      [2:0]                mem_size,
	output logic                           exc_align,
	output logic                           exc_tlb_miss,
	output logic                           exc_page_fault,
	output logic                           exc_bus_error,
	output logic                           illegal_insn
);
	import jlle_pkg::*;
	// ************************************************************
	// decode
	// ************************************************************
	wire logic [5:0]      opc      = insn[OPC_HI:OPC_LO];
	wire logic [4:0]      dfield   = insn[FD_HI:FD_LO];
	wire logic [XLEN-1:0] imm_sx   = {{(XLEN-16){insn[IMM_HI]}}, insn[IMM_HI:IMM_LO]};
	wire logic            is_jal   = opc == OP_JAL;
	wire logic            is_jr    = opc == OP_JR;
	wire logic            is_jalr  = opc == OP_JALR;
	wire logic            is_ld    = opc == OP_LD;
	wire logic            is_load  = (opc == OP_LBS) | (opc == OP_LBZ) | (opc == OP_LHS) |
	                                 (opc == OP_LHZ) | is_ld | (opc == OP_LF);
	wire logic            is_link  = is_jal | is_jalr;
	wire logic [XLEN-1:0] jal_off  = {{(XLEN-28){insn[25]}}, insn[25:0], 2'b00};
	// size, sign and boxing selection for the load group
	wire logic [2:0] ld_size = ((opc == OP_LBS) | (opc == OP_LBZ)) ? 3'(JLLE_SZ_B) :
	                           ((opc == OP_LHS) | (opc == OP_LHZ)) ? 3'(JLLE_SZ_H) :
	                           is_ld ? 3'(JLLE_SZ_D) : 3'(JLLE_SZ_W);
	wire logic       ld_sign = (opc == OP_LBS) | (opc == OP_LHS);
	wire logic       ld_box  = opc == OP_LF;
	// address and target computation
	wire logic [XLEN-1:0] addr_sum = base_source_reg + imm_sx;
	wire logic [XLEN-1:0] addr_eff = mode64 ? addr_sum : {32'h00000000, addr_sum[31:0]};
	wire logic [XLEN-1:0] tgt      = is_jal ? insn_addr + jal_off : target_source_reg;
	// link value: no slot means jump address plus four, else slot address plus four
	wire logic [XLEN-1:0] link_val = no_delay_slot_cfg ? insn_addr + INSN_STEP :
	                                 insn_addr + INSN_STEP + INSN_STEP;
	// alignment: register jumps need word, byte loads never checked
	wire logic jmp_mis  = (is_jr | is_jalr) & (tgt[1:0] != 2'b00);
	wire logic ld_mis   = (ld_size == 3'(JLLE_SZ_H)) ? addr_eff[0] :
	                      (ld_size == 3'(JLLE_SZ_W)) ? (addr_eff[1:0] != 2'b00) :
	                      (ld_size == 3'(JLLE_SZ_D)) ? (addr_eff[2:0] != 3'b000) :
	                      1'b0;
	wire logic ld_illeg = is_ld & ~mode64;
	// shaping attributes are declared ahead of the extender that reads them
	logic                 sign_ff;
	logic                 box_ff;
	wire logic [XLEN-1:0] ld_shaped;
	jlle_load_ext u_ext (
		.raw      (mem_rdata),
		.size     (mem_size),
		.sign_ext (sign_ff),
		.nan_box  (box_ff),
		.mode64   (mode64),
		.result   (ld_shaped)
	);
	// ************************************************************
	// sequencer
	// ************************************************************
	jlle_state_t state_ff;
	wire logic   take    = insn_valid & insn_ready;
	wire logic   go_jump = take & (is_jr | is_link) & ~jmp_mis;
	wire logic   go_load = take & is_load & ~ld_mis & ~ld_illeg;
	wire logic   mem_fin = mem_ack | mem_err | mem_tlb_miss | mem_page_fault;
	// the slot state holds the redirect until the single slot instruction passes
	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= JLLE_IDLE;
		end else begin
			case (state_ff)
				JLLE_IDLE: begin
					if (go_load)
						state_ff <= JLLE_LOAD;
					else if (go_jump & ~no_delay_slot_cfg)
						state_ff <= JLLE_SLOT;
				end
				JLLE_SLOT: if (insn_valid) state_ff <= JLLE_IDLE;
				JLLE_LOAD: if (mem_fin) state_ff <= JLLE_IDLE;
				default:   state_ff <= JLLE_IDLE;
			endcase
		end
	end
	// pending jump target carried through the delay slot
	logic [XLEN-1:0] pend_tgt_ff;
	always_ff @(posedge clock) begin
		if (rst) pend_tgt_ff <= '0;
		else if (go_jump) pend_tgt_ff <= tgt;
	end
	// redirect: immediately with no slot, else after the slot instruction
	always_ff @(posedge clock) begin
		if (rst) begin
			pc_load   <= 1'b0;
			pc_target <= '0;
		end else begin
			pc_load   <= (go_jump & no_delay_slot_cfg) | (state_ff == JLLE_SLOT & insn_valid);
			pc_target <= (state_ff == JLLE_SLOT) ? pend_tgt_ff : tgt;
		end
	end
	// link is visible from the cycle after the jump, so the slot reads the new value;
	// a slot write arrives later and therefore replaces it for good
	always_ff @(posedge clock) begin
		if (rst) link_reg <= '0;
		else if (state_ff == JLLE_SLOT && insn_valid && slot_wr_link)
			link_reg <= slot_wr_data;
		else if (go_jump & is_link)
			link_reg <= link_val;
	end
	// load request and shaping attributes held while memory works
	always_ff @(posedge clock) begin
		if (rst) begin
			mem_req           <= 1'b0;
			effective_address <= '0;
			mem_size          <= 3'(JLLE_SZ_B);
			sign_ff           <= 1'b0;
			box_ff            <= 1'b0;
			wb_dest           <= 5'h00;
		end else if (go_load) begin
			mem_req           <= 1'b1;
			effective_address <= addr_eff;
			mem_size          <= ld_size;
			sign_ff           <= ld_sign;
			box_ff            <= ld_box;
			wb_dest           <= dfield;
		end else if (go_jump & is_link) begin
			wb_dest           <= LINK_REG_IDX;
		end else if (mem_fin) begin
			mem_req           <= 1'b0;
		end
	end
	// writeback of loaded data or link value
	always_ff @(posedge clock) begin
		if (rst) begin
			wb_valid <= 1'b0;
			wb_data  <= '0;
		end else begin
			wb_valid <= (state_ff == JLLE_LOAD & mem_ack) | (go_jump & is_link);
			wb_data  <= (state_ff == JLLE_LOAD) ? ld_shaped : link_val;
		end
	end
	// exception pulses; memory faults come back from the translation/bus side
	always_ff @(posedge clock) begin
		if (rst) begin
			exc_align      <= 1'b0;
			exc_tlb_miss   <= 1'b0;
			exc_page_fault <= 1'b0;
			exc_bus_error  <= 1'b0;
			illegal_insn   <= 1'b0;
			insn_ready     <= 1'b0;
		end else begin
			exc_align      <= take & (jmp_mis | (is_load & ~ld_illeg & ld_mis));
			exc_tlb_miss   <= state_ff == JLLE_LOAD & mem_tlb_miss;
			exc_page_fault <= state_ff == JLLE_LOAD & mem_page_fault;
			exc_bus_error  <= state_ff == JLLE_LOAD & mem_err;
			illegal_insn   <= take & ld_illeg;
			insn_ready     <= ~(go_load | (state_ff == JLLE_LOAD & ~mem_fin));
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	a_link_no_slot: assert property (@(posedge clock) disable iff (rst)
		go_jump & is_link & no_delay_slot_cfg |=> link_reg == $past(insn_addr) + INSN_STEP)
		else $error("link value wrong without delay slot");
	a_slot_then_jump: assert property (@(posedge clock) disable iff (rst)
		go_jump & ~no_delay_slot_cfg |=> ~pc_load)
		else $error("jump taken before delay slot");
	a_jr_target: assert property (@(posedge clock) disable iff (rst)
		go_jump & is_jr & no_delay_slot_cfg |=> pc_load && pc_target == $past(target_source_reg))
		else $error("register jump target wrong");
	a_slot_wins: assert property (@(posedge clock) disable iff (rst)
		state_ff == JLLE_SLOT & insn_valid & slot_wr_link |=> link_reg == $past(slot_wr_data))
		else $error("slot write lost");
	a_byte_align: assert property (@(posedge clock) disable iff (rst)
		take & is_load & ld_size == 3'(JLLE_SZ_B) |=> ~exc_align)
		else $error("byte load raised alignment");
	a_addr_sum: assert property (@(posedge clock) disable iff (rst)
		go_load & mode64 |=> effective_address == $past(base_source_reg) + $past(imm_sx))
		else $error("effective address wrong");
	a_ld_32bit: assert property (@(posedge clock) disable iff (rst)
		take & is_ld & ~mode64 |=> illegal_insn && !mem_req)
		else $error("double load accepted in 32-bit mode");
	a_sbyte_fill: assert property (@(posedge clock) disable iff (rst)
		state_ff == JLLE_LOAD & mem_ack & sign_ff & mem_size == 3'(JLLE_SZ_B)
		|=> wb_data == {{(XLEN-8){$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
		else $error("signed byte fill wrong");
	c_link_slot: cover property (@(posedge clock) go_jump & is_link & ~no_delay_slot_cfg);
	c_load_done: cover property (@(posedge clock) state_ff == JLLE_LOAD & mem_ack);
	c_jump_misal: cover property (@(posedge clock) take & jmp_mis);
endmodule

// *** verif/jlle_mem_model.sv ***
// jlle_mem_model: data memory side, answers each load request once
// assumes the core holds mem_req until it sees a completion pulse
`timescale 1ns/1ps
module jlle_mem_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        mem_req,
	input  wire logic [63:0] mem_value,
	input  wire logic [1:0]  mem_fault,
	input  wire logic [3:0]  mem_delay,
	output logic             mem_ack,
	output logic             mem_err,
	output logic             mem_tlb_miss,
	output logic             mem_page_fault,
	output logic      [63:0] mem_rdata
);
	logic [3:0] wait_ff;
	logic       done_ff;
	// ************************************************************
	// one completion per request, after mem_delay cycles
	// ************************************************************
	// data outside the completion cycle is inverted so a late sample is caught
	always_ff @(posedge clock) begin
		mem_ack        <= 1'b0;
		mem_err        <= 1'b0;
		mem_tlb_miss   <= 1'b0;
		mem_page_fault <= 1'b0;
		mem_rdata      <= ~mem_value;
		if (rst || !mem_req) begin
			wait_ff <= 4'h0;
			done_ff <= 1'b0;
		end else if (!done_ff && wait_ff != mem_delay) begin
			wait_ff <= wait_ff + 4'h1;
		end else if (!done_ff) begin
			done_ff        <= 1'b1;
			mem_ack        <= (mem_fault == 2'h0);
			mem_err        <= (mem_fault == 2'h1);
			mem_tlb_miss   <= (mem_fault == 2'h2);
			mem_page_fault <= (mem_fault == 2'h3);
			mem_rdata      <= mem_value;
		end
	end
endmodule

// *** verif/jump_link_and_load_exec_test.sv ***
// jump_link_and_load_exec_test: scenario bench for jlle_exec
// assumes jlle_mem_model stands on the memory side
`timescale 1ns/1ps
module jump_link_and_load_exec_test;
	import jlle_pkg::*;
	logic        clock = 1'b0, rst = 1'b1, insn_valid = 1'b0, slot_wr_link = 1'b0;
	logic        no_delay_slot_cfg = 1'b1, mode64 = 1'b1;
	logic [31:0] insn = 32'h0;
	logic [63:0] insn_addr = 64'h0, base_source_reg = 64'h0, target_source_reg = 64'h0;
	logic [63:0] slot_wr_data = 64'h0, mem_value = 64'h0123456789ABCDEF;
	logic [63:0] mem_rdata, pc_target, link_reg, wb_data, effective_address, link_at_take;
	logic [4:0]  wb_dest;
	logic [2:0]  mem_size;
	logic [1:0]  mem_fault = 2'h0;
	logic [3:0]  mem_delay = 4'h0;
	logic        insn_ready, pc_load, wb_valid, mem_req, exc_align, exc_tlb_miss, illegal_insn;
	logic        exc_page_fault, exc_bus_error, mem_ack, mem_err, mem_tlb_miss, mem_page_fault;
	logic        align_seen, pc_at_take;
	wire  [7:0]  ev = {exc_page_fault, exc_tlb_miss, exc_bus_error, mem_req, illegal_insn,
		exc_align, pc_load, wb_valid};
	int          fail_count = 0;
	int          comparisons = 0;
	// ************************************************************
	// clock, design and memory side
	// ************************************************************
	always #2.5 clock = ~clock;
	jlle_exec DUT (.clock, .rst, .insn_valid, .insn, .insn_addr, .base_source_reg,
		.target_source_reg, .no_delay_slot_cfg, .mode64, .slot_wr_link, .slot_wr_data,
		.mem_ack, .mem_err, .mem_tlb_miss, .mem_page_fault, .mem_rdata, .insn_ready, .pc_load,
		.pc_target, .link_reg, .wb_valid, .wb_dest, .wb_data, .mem_req, .effective_address,
		.mem_size, .exc_align, .exc_tlb_miss, .exc_page_fault, .exc_bus_error, .illegal_insn);
	jlle_mem_model MEM (.clock, .rst, .mem_req, .mem_value, .mem_fault, .mem_delay, .mem_ack,
		.mem_err, .mem_tlb_miss, .mem_page_fault, .mem_rdata);
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// called at a rising edge; returns at the edge that takes the word
	task automatic issue(input logic [31:0] word, input logic [63:0] addr, input logic last);
		int n;
		insn_valid <= 1'b1;
		insn <= word;
		insn_addr <= addr;
		for (n = 0; n < 20; n++) begin
			@(negedge clock);
			if (insn_ready === 1'b1)
				break;
		end
		link_at_take = link_reg;
		pc_at_take = pc_load;
		if (n == 20) begin
			chk("insn_ready", 64'h1, 64'h0);
			final_report();
		end
		@(posedge clock);
		if (last) begin
			insn_valid <= 1'b0;
			slot_wr_link <= 1'b0;
		end
	endtask
	// bounded wait for one output pulse, sampled between edges
	task automatic wait_ev(input int which);
		int n;
		align_seen = 1'b0;
		for (n = 0; n < 30; n++) begin
			@(negedge clock);
			align_seen = align_seen | (exc_align === 1'b1);
			if (ev[which] === 1'b1)
				break;
		end
		if (n == 30) begin
			chk("event", 64'h1, 64'h0);
			final_report();
		end
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_jal();
		@(posedge clock);
		issue({OP_JAL, 26'h0000010}, 64'h2000, 1'b1);
		wait_ev(1);
		chk("pc_target", 64'h2040, pc_target);
		chk("link_reg", 64'h2004, link_reg);
		chk("wb_dest", 64'h9, {59'h0, wb_dest});
	endtask
	task automatic t_jalr_slot();
		@(posedge clock);
		no_delay_slot_cfg <= 1'b0;
		target_source_reg <= 64'h3000;
		issue({OP_JALR, 10'h0, 5'h04, 11'h0}, 64'h2100, 1'b0);
		slot_wr_link <= 1'b1;
		slot_wr_data <= 64'h5555;
		issue(32'h15000000, 64'h2104, 1'b1);
		chk("link_reg", 64'h2108, link_at_take);
		chk("pc_load", 64'h0, {63'h0, pc_at_take});
		wait_ev(1);
		chk("pc_target", 64'h3000, pc_target);
		@(negedge clock);
		chk("link_reg", 64'h5555, link_reg);
	endtask
	task automatic t_jumps();
		@(posedge clock);
		no_delay_slot_cfg <= 1'b1;
		target_source_reg <= 64'h4000;
		issue({OP_JR, 10'h0, 5'h04, 11'h0}, 64'h2200, 1'b1);
		wait_ev(1);
		chk("pc_target", 64'h4000, pc_target);
		@(posedge clock);
		target_source_reg <= 64'h4002;
		issue({OP_JR, 10'h0, 5'h04, 11'h0}, 64'h2300, 1'b1);
		wait_ev(2);
		@(posedge clock);
		issue({OP_JALR, 10'h0, 5'h04, 11'h0}, 64'h2400, 1'b1);
		wait_ev(2);
		chk("link_reg", 64'h5555, link_reg);
	endtask
	task automatic t_load(input logic [5:0] op, input logic [2:0] sz, input logic [63:0] exp);
		@(posedge clock);
		base_source_reg <= 64'h1000;
		issue({op, 5'h03, 5'h01, 16'hFFF8}, 64'h100, 1'b1);
		wait_ev(4);
		chk("effective_address", 64'hFF8, effective_address);
		chk("mem_size", {61'h0, sz}, {61'h0, mem_size});
		wait_ev(0);
		chk("wb_dest", 64'h3, {59'h0, wb_dest});
		chk("wb_data", exp, wb_data);
	endtask
	// misaligned loads by size, then memory faults on an odd byte address
	task automatic t_faults();
		logic [5:0] ops [3] = '{OP_LHS, OP_LHZ, OP_LD};
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			base_source_reg <= 64'h1001 + 64'(i * 2);
			issue({ops[i], 5'h03, 5'h01, 16'h0000}, 64'h300, 1'b1);
			wait_ev(2);
		end
		for (int f = 1; f < 4; f++) begin
			@(posedge clock);
			mem_fault <= 2'(f);
			mem_delay <= 4'h3;
			issue({OP_LBS, 5'h03, 5'h01, 16'h0000}, 64'h400, 1'b1);
			wait_ev(4 + f);
			chk("exc_align", 64'h0, {63'h0, align_seen});
		end
		@(posedge clock);
		mem_fault <= 2'h0;
		mode64 <= 1'b0;
		issue({OP_LD, 5'h03, 5'h01, 16'h0000}, 64'h500, 1'b1);
		wait_ev(3);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_jal();
		t_jalr_slot();
		t_jumps();
		t_load(OP_LBS, 3'h0, 64'hFFFFFFFFFFFFFFEF);
		t_load(OP_LBZ, 3'h0, 64'h00000000000000EF);
		t_load(OP_LHS, 3'h1, 64'hFFFFFFFFFFFFCDEF);
		t_load(OP_LHZ, 3'h1, 64'h000000000000CDEF);
		t_load(OP_LD, 3'h3, 64'h0123456789ABCDEF);
		t_load(OP_LF, 3'h2, 64'hFFFFFFFF89ABCDEF);
		t_faults();
		final_report();
	end
endmodule
